// ### aovs_conv.sv
// Behavioural model of the voltage and current loop converters.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Converter model
// ****************************************
module aovs_conv
(
    // Codes from the selector.
    input wire [7:0] volt_code,
    input wire [7:0] curr_code,
    // Output levels in mV and in uA.
    output wire [15:0] out_mv,
    output wire [15:0] out_ua
);
    // Codes drive levels directly.
    // An unknown code stays unknown, so a bad code never looks like 0 V.
    assign out_mv = {8'h00, volt_code} * 16'h0032;
    assign out_ua = {8'h00, curr_code} * 16'h0064;
endmodule
`default_nettype wire

// ### aovs_defines.vh
// Constants for the analog output value selector: map, fields, limits.
`ifndef AOVS_DEFINES_VH
`define AOVS_DEFINES_VH
// Register byte offsets.
`define AOVS_CTRL_OFS 8'h00
`define AOVS_VOLT_OFS 8'h04
`define AOVS_CURR_OFS 8'h08
`define AOVS_NTD_OFS 8'h0C
`define AOVS_NSD_OFS 8'h10
`define AOVS_STAT_OFS 8'h14
// Control field positions.
`define AOVS_PU_V_BIT 0
`define AOVS_PU_I_BIT 1
`define AOVS_NT_V_LSB 2
`define AOVS_NT_I_LSB 4
`define AOVS_NS_V_LSB 6
`define AOVS_NS_I_LSB 8
`define AOVS_SLAVE_BIT 10
// Value register field positions: low code and high code.
`define AOVS_LO_LSB 0
`define AOVS_HI_LSB 16
// Status field positions.
`define AOVS_ST_DONE_BIT 0
`define AOVS_ST_NT_BIT 1
`define AOVS_ST_NS_BIT 2
`define AOVS_ST_RED_BIT 3
`define AOVS_ST_ERR_BIT 4
`define AOVS_ST_V_LSB 8
`define AOVS_ST_I_LSB 16
// Fallback modes.
`define AOVS_MODE_HOLD 2'h0
`define AOVS_MODE_LOW 2'h1
`define AOVS_MODE_HIGH 2'h2
// Reset values (voltage in 50 mV codes, current in 0.1 mA codes).
`define AOVS_CTRL_RST 11'h000
`define AOVS_VHI_RST 8'hC8
`define AOVS_VLO_RST 8'h00
`define AOVS_IHI_RST 8'hC8
`define AOVS_ILO_RST 8'h28
`define AOVS_DLY_RST 16'h0000
// Accepted ranges and least separation.
`define AOVS_VHI_MIN 8'h02
`define AOVS_VHI_MAX 8'hC8
`define AOVS_VLO_MAX 8'hC6
`define AOVS_V_SEP 9'h014
`define AOVS_IHI_MIN 8'h16
`define AOVS_IHI_MAX 8'hC8
`define AOVS_ILO_MIN 8'h14
`define AOVS_ILO_MAX 8'hC7
`define AOVS_I_SEP 9'h014
`define AOVS_DLY_MAX 16'hFFF0
// Push-button teach steps and the voltage high values they load.
`define AOVS_TEACH_5V 6'h1E
`define AOVS_TEACH_10V 6'h1F
`define AOVS_V5_CODE 8'h64
`define AOVS_V10_CODE 8'hC8
// Delay time base: unit in ms, clock in kHz.
`define AOVS_TICK_MS 5
`define AOVS_CLK_KHZ 25000
`define AOVS_TICK_CYCLES (`AOVS_TICK_MS * `AOVS_CLK_KHZ)
`endif

// ### aovs_selector.v
// Analog output value selector with its AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "aovs_defines.vh"

module aovs_selector
#(
    parameter TICK_CYCLES = `AOVS_TICK_CYCLES
)
(
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Measurement results.
    input wire meas_valid,
    input wire meas_target,
    input wire [1:0] meas_zone,
    input wire [7:0] meas_frac,
    // Master sync and push-button teach.
    input wire sync_pulse,
    input wire teach_valid,
    input wire [5:0] teach_step,
    // Converter codes and indicator.
    output reg [7:0] volt_code,
    output reg [7:0] curr_code,
    output reg led_red
);

    // *************************************************************
    // Declarations
    // *************************************************************

    // Zone codes of a measurement: inside, at/beyond low, high.
    localparam [1:0] ZONE_LOW = 2'h1;
    localparam [1:0] ZONE_HIGH = 2'h2;

    // Configuration registers.
    reg [10:0] ctrl_ff;
    reg [7:0] vhi_ff;
    reg [7:0] vlo_ff;
    reg [7:0] ihi_ff;
    reg [7:0] ilo_ff;
    reg [15:0] ntd_ff;
    reg [15:0] nsd_ff;
    // Sticky flag for a refused configuration write.
    reg err_ff;
    // Captured address phase.
    reg wr_pend_ff;
    reg [7:0] addr_ff;
    // Time base and delay counters.
    reg [16:0] tick_cnt_ff;
    reg tick_ff;
    reg fail_ff;
    reg [15:0] nt_cnt_ff;
    reg [16:0] ns_cnt_ff;
    reg done_ff;
    // Next values.
    reg [7:0] nxt_volt;
    reg [7:0] nxt_curr;
    reg nxt_err;
    // Decoded helpers.
    wire addr_ok;
    wire wr_en;
    wire rd_en;
    wire nt_act;
    wire ns_act;
    wire [31:0] stat_word;
    wire [7:0] wv_lo;
    wire [7:0] wv_hi;
    wire v_good;
    wire i_good;
    wire [15:0] v_prod;
    wire [15:0] i_prod;
    wire [7:0] v_scaled;
    wire [7:0] i_scaled;

    // *************************************************************
    // Helper functions
    // *************************************************************

    // Picks the fallback value for a mode; HOLD keeps the output.
    function [7:0] pick;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        input [7:0] keep;
        begin
            if (mode == `AOVS_MODE_LOW)
            begin
                pick = lo;
            end
            else if (mode == `AOVS_MODE_HIGH)
            begin
                pick = hi;
            end
            else
            begin
                pick = keep;
            end
        end
    endfunction

    // *************************************************************
    // Bus slave
    // *************************************************************

    // The slave never stalls and never reports an error.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // A transfer is taken on NONSEQ or SEQ with hready high.
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_en = wr_pend_ff;
    assign rd_en = addr_ok & ~hwrite;

    // The write data of the pending write, split into two codes.
    assign wv_lo = hwdata[`AOVS_LO_LSB +: 8];
    assign wv_hi = hwdata[`AOVS_HI_LSB +: 8];

    assign v_good = (wv_hi >= `AOVS_VHI_MIN) &&
        (wv_hi <= `AOVS_VHI_MAX) && (wv_lo <= `AOVS_VLO_MAX) &&
        ({1'b0, wv_hi} >= {1'b0, wv_lo} + `AOVS_V_SEP);

    assign i_good = (wv_hi >= `AOVS_IHI_MIN) &&
        (wv_hi <= `AOVS_IHI_MAX) && (wv_lo >= `AOVS_ILO_MIN) &&
        (wv_lo <= `AOVS_ILO_MAX) &&
        ({1'b0, wv_hi} >= {1'b0, wv_lo} + `AOVS_I_SEP);

    // Address phase capture; the data follows in the next cycle.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= addr_ok & hwrite;
            addr_ff <= haddr;
        end
    end

    // Read data is registered at the address phase, so it is
    // stable across the whole data phase.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (rd_en)
        begin
            case (haddr)
                `AOVS_CTRL_OFS: hrdata <= {21'h000000, ctrl_ff};
                `AOVS_VOLT_OFS: hrdata <= {8'h00, vhi_ff, 8'h00, vlo_ff};
                `AOVS_CURR_OFS: hrdata <= {8'h00, ihi_ff, 8'h00, ilo_ff};
                `AOVS_NTD_OFS: hrdata <= {16'h0000, ntd_ff};
                `AOVS_NSD_OFS: hrdata <= {16'h0000, nsd_ff};
                `AOVS_STAT_OFS: hrdata <= stat_word;
                // Unmapped words read as zero.
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Status word shows the live selector state.
    assign stat_word = {8'h00, curr_code, volt_code, 3'h0, err_ff,
        led_red, ns_act, nt_act, done_ff};

    // *************************************************************
    // Configuration registers
    // *************************************************************

    // Writes that break a range or separation are refused whole,
    // so the pair of codes can never be left half updated.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= `AOVS_CTRL_RST;
            vhi_ff <= `AOVS_VHI_RST;
            vlo_ff <= `AOVS_VLO_RST;
            ihi_ff <= `AOVS_IHI_RST;
            ilo_ff <= `AOVS_ILO_RST;
            ntd_ff <= `AOVS_DLY_RST;
            nsd_ff <= `AOVS_DLY_RST;
        end
        else
        begin
            if (wr_en && addr_ff == `AOVS_CTRL_OFS)
            begin
                ctrl_ff <= hwdata[10:0];
            end
            if (wr_en && addr_ff == `AOVS_VOLT_OFS && v_good)
            begin
                vhi_ff <= wv_hi;
                vlo_ff <= wv_lo;
            end
            if (wr_en && addr_ff == `AOVS_CURR_OFS && i_good)
            begin
                ihi_ff <= wv_hi;
                ilo_ff <= wv_lo;
            end
            if (wr_en && addr_ff == `AOVS_NTD_OFS &&
                hwdata[15:0] <= `AOVS_DLY_MAX && hwdata[31:16] == 16'h0)
            begin
                ntd_ff <= hwdata[15:0];
            end
            if (wr_en && addr_ff == `AOVS_NSD_OFS &&
                hwdata[15:0] <= `AOVS_DLY_MAX && hwdata[31:16] == 16'h0)
            begin
                nsd_ff <= hwdata[15:0];
            end
            if (teach_valid && (teach_step == `AOVS_TEACH_5V ||
                teach_step == `AOVS_TEACH_10V))
            begin
                vhi_ff <= (teach_step == `AOVS_TEACH_5V) ?
                    `AOVS_V5_CODE : `AOVS_V10_CODE;
                vlo_ff <= `AOVS_VLO_RST;
            end
        end
    end

    // Refused writes set the error flag; writing one to it
    // clears it, but a refusal in the same cycle wins.
    always @*
    begin
        nxt_err = err_ff;
        if (wr_en && addr_ff == `AOVS_STAT_OFS &&
            hwdata[`AOVS_ST_ERR_BIT])
        begin
            nxt_err = 1'b0;
        end
        if (wr_en && ((addr_ff == `AOVS_VOLT_OFS && !v_good) ||
            (addr_ff == `AOVS_CURR_OFS && !i_good) ||
            ((addr_ff == `AOVS_NTD_OFS || addr_ff == `AOVS_NSD_OFS) &&
            (hwdata[15:0] > `AOVS_DLY_MAX || hwdata[31:16] != 16'h0))))
        begin
            nxt_err = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            err_ff <= 1'b0;
        end
        else
        begin
            err_ff <= nxt_err;
        end
    end

    // *************************************************************
    // Time base and delay tracking
    // *************************************************************

    // A one-cycle tick every delay unit.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_ff <= 17'h00000;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == TICK_CYCLES[16:0] - 17'h00001)
        begin
            tick_cnt_ff <= 17'h00000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 17'h00001;
            tick_ff <= 1'b0;
        end
    end

    // Red while target missing.
    // Any measurement that sees a target restarts the count.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fail_ff <= 1'b0;
            nt_cnt_ff <= 16'h0000;
            led_red <= 1'b0;
        end
        else
        begin
            led_red <= fail_ff;
            if (meas_valid && meas_target)
            begin
                fail_ff <= 1'b0;
                nt_cnt_ff <= 16'h0000;
            end
            else if (meas_valid)
            begin
                fail_ff <= 1'b1;
            end
            else if (fail_ff && tick_ff && nt_cnt_ff != 16'hFFFF)
            begin
                nt_cnt_ff <= nt_cnt_ff + 16'h0001;
            end
        end
    end

    assign nt_act = fail_ff && (nt_cnt_ff >= ntd_ff);

    // Units since the last master sync; a slave that misses more
    // than the delay is out of sync. Saturates, never wraps.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ns_cnt_ff <= 17'h00000;
        end
        else if (sync_pulse)
        begin
            ns_cnt_ff <= 17'h00000;
        end
        else if (tick_ff && ns_cnt_ff != 17'h1FFFF)
        begin
            ns_cnt_ff <= ns_cnt_ff + 17'h00001;
        end
    end

    assign ns_act = ctrl_ff[`AOVS_SLAVE_BIT] &&
        (ns_cnt_ff > {1'b0, nsd_ff});

    // *************************************************************
    // Output selection
    // *************************************************************

    assign v_prod = (vhi_ff - vlo_ff) * meas_frac;
    assign i_prod = (ihi_ff - ilo_ff) * meas_frac;
    assign v_scaled = vlo_ff + v_prod[15:8];
    assign i_scaled = ilo_ff + i_prod[15:8];

    // Priority: power-up, lost sync, no target, fresh measurement.
    always @*
    begin
        nxt_volt = volt_code;
        nxt_curr = curr_code;
        if (!done_ff && !meas_valid)
        begin
            nxt_volt = ctrl_ff[`AOVS_PU_V_BIT] ? vhi_ff : vlo_ff;
            nxt_curr = ctrl_ff[`AOVS_PU_I_BIT] ? ihi_ff : ilo_ff;
        end
        else if (ns_act)
        begin
            nxt_volt = pick(ctrl_ff[`AOVS_NS_V_LSB +: 2], vlo_ff,
                vhi_ff, volt_code);
            nxt_curr = pick(ctrl_ff[`AOVS_NS_I_LSB +: 2], ilo_ff,
                ihi_ff, curr_code);
        end
        else if (nt_act)
        begin
            nxt_volt = pick(ctrl_ff[`AOVS_NT_V_LSB +: 2], vlo_ff,
                vhi_ff, volt_code);
            nxt_curr = pick(ctrl_ff[`AOVS_NT_I_LSB +: 2], ilo_ff,
                ihi_ff, curr_code);
        end
        else if (meas_valid && meas_target)
        begin
            if (meas_zone == ZONE_LOW)
            begin
                nxt_volt = vlo_ff;
                nxt_curr = ilo_ff;
            end
            else if (meas_zone == ZONE_HIGH)
            begin
                nxt_volt = vhi_ff;
                nxt_curr = ihi_ff;
            end
            else
            begin
                nxt_volt = v_scaled;
                nxt_curr = i_scaled;
            end
        end
    end

    // Codes registered straight out.
    // Outputs reset to the default low codes, which equal the
    // power-up LOW selection, so no glitch at release.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            volt_code <= `AOVS_VLO_RST;
            curr_code <= `AOVS_ILO_RST;
            done_ff <= 1'b0;
        end
        else
        begin
            volt_code <= nxt_volt;
            curr_code <= nxt_curr;
            if (meas_valid)
            begin
                done_ff <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ### aovs_selector_assertions.sv
// Concurrent checks on the selector's ports.
`timescale 1ns/1ps
`default_nettype none
`include "aovs_defines.vh"
// ****************************************
// Port checker
// ****************************************
module aovs_selector_chk
#(
    parameter TICK_CYCLES = `AOVS_TICK_CYCLES
)
(
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // Bus.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Measurement, teach and outputs.
    input wire meas_valid,
    input wire meas_target,
    input wire teach_valid,
    input wire [7:0] volt_code,
    input wire [7:0] curr_code,
    input wire led_red
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A read address phase is taken at this edge.
    wire rd_take = hsel && hready && htrans[1] && !hwrite;

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Slave response is not OKAY.");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("Slave inserted a wait state.");
    a_reset_low: assert property ($rose(hresetn) |->
        volt_code == `AOVS_VLO_RST && curr_code == `AOVS_ILO_RST)
        else $error("Outputs left the power-up low values.");
    a_volt_range: assert property (volt_code <= `AOVS_VHI_MAX)
        else $error("Voltage code above its range.");
    a_curr_range: assert property (curr_code >= `AOVS_ILO_MIN &&
        curr_code <= `AOVS_IHI_MAX)
        else $error("Current code outside its range.");
    a_red_on: assert property (meas_valid && !meas_target |->
        ##2 led_red)
        else $error("Indicator not red after a missed target.");
    a_red_cause: assert property ($changed(led_red) |->
        $past(meas_valid, 2))
        else $error("Indicator moved without a measurement.");
    a_stat_read: assert property (rd_take &&
        haddr == `AOVS_STAT_OFS |=> hrdata[15:8] == $past(volt_code) &&
        hrdata[23:16] == $past(curr_code) && hrdata[3] == $past(led_red))
        else $error("Status read does not mirror the outputs.");
    a_unmapped_zero: assert property (rd_take && haddr >= 8'h18 |=>
        hrdata == 32'h00000000)
        else $error("Unmapped read returned data.");

    c_fail: cover property (meas_valid && !meas_target);
    c_stat: cover property (rd_take && haddr == `AOVS_STAT_OFS);
    c_teach: cover property (teach_valid);
endmodule

bind aovs_selector aovs_selector_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .meas_valid(meas_valid), .meas_target(meas_target),
    .teach_valid(teach_valid), .volt_code(volt_code),
    .curr_code(curr_code), .led_red(led_red));
`default_nettype wire

// ### aovs_selector_test.sv
// Self-checking bench for the analog output value selector.
`timescale 1ns/1ps
`default_nettype none
`include "aovs_defines.vh"
// ****************************************
// Bench top
// ****************************************
module aovs_selector_test;
    // A short time base keeps the delay scenarios brief.
    localparam TICK = 10;
    // Stimulus, all driven from the rising edge.
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h00000000;
    reg meas_valid = 1'b0;
    reg meas_target = 1'b0;
    reg [1:0] meas_zone = 2'h0;
    reg [7:0] meas_frac = 8'h00;
    reg sync_pulse = 1'b0;
    reg teach_valid = 1'b0;
    reg [5:0] teach_step = 6'h00;
    // Design outputs and converter levels.
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire [7:0] volt_code;
    wire [7:0] curr_code;
    wire led_red;
    wire [15:0] out_mv;
    wire [15:0] out_ua;
    // Bookkeeping and the last read word.
    integer errors = 0;
    integer checks_done = 0;
    reg [31:0] rd;

    // The single slave's ready is the bus ready.
    aovs_selector #(.TICK_CYCLES(TICK)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .meas_valid(meas_valid),
        .meas_target(meas_target), .meas_zone(meas_zone),
        .meas_frac(meas_frac), .sync_pulse(sync_pulse),
        .teach_valid(teach_valid), .teach_step(teach_step),
        .volt_code(volt_code), .curr_code(curr_code), .led_red(led_red));
    aovs_conv i_conv (.volt_code(volt_code), .curr_code(curr_code),
        .out_mv(out_mv), .out_ua(out_ua));

    // Clock of 40 ns.
    always #20 hclk = ~hclk;

    // Prints the verdict and ends the run.
    task results;
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Compares one value; four-state so unknowns never match.
    task ck(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares both converter codes.
    task cc(input [7:0] v, input [7:0] i);
        ck(volt_code, v);
        ck(curr_code, i);
    endtask

    // One single word transfer; each phase is held until hready.
    task xfer(input w, input [7:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Reads a word and compares it.
    task rc(input [7:0] a, input [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        ck(rd, e);
    endtask

    // Writes a word, then reads it back.
    task wc(input [7:0] a, input [31:0] d, input [31:0] e);
        xfer(1'b1, a, d);
        rc(a, e);
    endtask

    // One measurement pulse; ends once codes and indicator have settled.
    task ms(input t, input [1:0] z, input [7:0] f);
        @(posedge hclk);
        meas_valid <= 1'b1;
        meas_target <= t;
        meas_zone <= z;
        meas_frac <= f;
        @(posedge hclk);
        meas_valid <= 1'b0;
        @(posedge hclk);
        #1;
    endtask

    // One-cycle master sync or teach pulse.
    task pulse(input s, input [5:0] step);
        @(posedge hclk);
        sync_pulse <= s;
        teach_valid <= !s;
        teach_step <= step;
        @(posedge hclk);
        sync_pulse <= 1'b0;
        teach_valid <= 1'b0;
    endtask

    // Reset held for 20 cycles.
    task rst;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
    endtask

    // The tests take well under a thousand cycles; this cuts a hang.
    initial
    begin
        repeat (5000) @(posedge hclk);
        errors = errors + 1;
        results;
    end

    // Main sequence.
    initial
    begin
        rst;
        cc(8'h00, 8'h28);
        ck(out_ua, 32'h00000FA0);
        rc(`AOVS_VOLT_OFS, 32'h00C80000);
        rc(`AOVS_CURR_OFS, 32'h00C80028);
        rc(`AOVS_NTD_OFS, 32'h00000000);
        rc(`AOVS_NSD_OFS, 32'h00000000);
        rc(`AOVS_CTRL_OFS, 32'h00000000);
        rc(8'h18, 32'h00000000);
        // Power-up HIGH is applied before the first measurement.
        xfer(1'b1, `AOVS_CTRL_OFS, 32'h00000003);
        repeat (2) @(posedge hclk);
        #1;
        cc(8'hC8, 8'hC8);
        ms(1'b1, 2'h0, 8'h80);
        cc(8'h64, 8'h78);
        ck(out_mv, 32'h00001388);
        ms(1'b1, 2'h1, 8'h00);
        cc(8'h00, 8'h28);
        ms(1'b1, 2'h2, 8'h00);
        cc(8'hC8, 8'hC8);
        ms(1'b1, 2'h0, 8'hFF);
        cc(8'hC7, 8'hC7);
        // Separation and range limits, accepted and refused.
        wc(`AOVS_VOLT_OFS, 32'h00280014, 32'h00280014);
        wc(`AOVS_VOLT_OFS, 32'h00280015, 32'h00280014);
        xfer(1'b0, `AOVS_STAT_OFS, 32'h00000000);
        ck(rd, 32'h00C7C711);
        ck(rd[4], 1'b1);
        xfer(1'b1, `AOVS_STAT_OFS, 32'h00000010);
        xfer(1'b0, `AOVS_STAT_OFS, 32'h00000000);
        ck(rd[4], 1'b0);
        wc(`AOVS_VOLT_OFS, 32'h00C90014, 32'h00280014);
        wc(`AOVS_CURR_OFS, 32'h00280013, 32'h00C80028);
        wc(`AOVS_CURR_OFS, 32'h00270014, 32'h00C80028);
        wc(`AOVS_CURR_OFS, 32'h00280014, 32'h00280014);
        wc(`AOVS_NTD_OFS, 32'h0000FFF1, 32'h00000000);
        wc(`AOVS_NTD_OFS, 32'h0000FFF0, 32'h0000FFF0);
        ms(1'b1, 2'h0, 8'h80);
        cc(8'h1E, 8'h1E);
        pulse(1'b0, `AOVS_TEACH_10V);
        rc(`AOVS_VOLT_OFS, 32'h00C80000);
        pulse(1'b0, `AOVS_TEACH_5V);
        rc(`AOVS_VOLT_OFS, 32'h00640000);
        // No target: voltage goes HIGH, current LOW after two ticks.
        wc(`AOVS_NTD_OFS, 32'h00000002, 32'h00000002);
        xfer(1'b1, `AOVS_CTRL_OFS, 32'h00000018);
        ms(1'b1, 2'h0, 8'h80);
        cc(8'h32, 8'h1E);
        ms(1'b0, 2'h0, 8'h00);
        cc(8'h32, 8'h1E);
        ck(led_red, 1'b1);
        repeat (40) @(posedge hclk);
        #1;
        cc(8'h64, 8'h14);
        xfer(1'b0, `AOVS_STAT_OFS, 32'h00000000);
        ck(rd[1], 1'b1);
        // Default HOLD with zero delay keeps the last codes.
        rst;
        ms(1'b1, 2'h2, 8'h00);
        ms(1'b0, 2'h0, 8'h00);
        repeat (10) @(posedge hclk);
        #1;
        cc(8'hC8, 8'hC8);
        xfer(1'b0, `AOVS_STAT_OFS, 32'h00000000);
        ck(rd[1], 1'b1);
        ck(rd[3], 1'b1);
        // Sync slave: measurements follow while syncs come, then HIGH.
        rst;
        xfer(1'b1, `AOVS_NSD_OFS, 32'h00000001);
        xfer(1'b1, `AOVS_CTRL_OFS, 32'h00000680);
        repeat (3)
        begin
            pulse(1'b1, 6'h00);
            ms(1'b1, 2'h0, 8'h80);
        end
        cc(8'h64, 8'h78);
        repeat (40) @(posedge hclk);
        #1;
        cc(8'hC8, 8'hC8);
        xfer(1'b0, `AOVS_STAT_OFS, 32'h00000000);
        ck(rd[2], 1'b1);
        results;
    end
endmodule
`default_nettype wire
